/* File: rtl/tgp_gate_protect.sv */
// gate drive protection top with axi4-lite registers
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tgp_gate_protect (
   input wire logic aclk,
   input wire logic aresetn,
   // phase inputs from controller
   input wire logic high_u_in,
   input wire logic high_v_in,
   input wire logic high_w_in,
   input wire logic low_u_in,
   input wire logic low_v_in,
   input wire logic low_w_in,
   // external shutdown and its presence
   input wire logic ext_shutdown_n,
   input wire logic ext_shutdown_conn,
   // comparator trips
   input wire logic current_sense_trip,
   input wire logic logic_supply_uv,
   input wire logic bootstrap_uv,
   input wire logic thermal_trip,
   // switch enables
   output logic gate_high_u,
   output logic gate_high_v,
   output logic gate_high_w,
   output logic gate_low_u,
   output logic gate_low_v,
   output logic gate_low_w,
   // open drain fault flag
   output logic fault_flag_o,
   output logic fault_flag_oe,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   ////////////////////////////////////////////////////////////////////////
   localparam int NSYNC = 12;
   // first and second stages
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic [NSYNC-1:0] raw;
   assign raw = {high_u_in, high_v_in, high_w_in, low_u_in, low_v_in, low_w_in,
                 ext_shutdown_n, ext_shutdown_conn, current_sense_trip,
                 logic_supply_uv, bootstrap_uv, thermal_trip};

   // two flops before any logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 12'h030;
         sync2_q <= 12'h030;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end

   // synchronised names
   logic [2:0] hi_s;
   logic [2:0] lo_s;
   logic sd_n_s;
   logic sd_conn_s;
   logic oc_s;
   logic luv_s;
   logic buv_s;
   logic th_s;
   assign hi_s = sync2_q[11:9]; // R18
   assign lo_s = sync2_q[8:6];
   assign sd_n_s = sync2_q[5];
   assign sd_conn_s = sync2_q[4];
   assign oc_s = sync2_q[3];
   assign luv_s = sync2_q[2];
   assign buv_s = sync2_q[1];
   assign th_s = sync2_q[0];

   ////////////////////////////////////////////////////////////////////////
   // control register
   ////////////////////////////////////////////////////////////////////////
   logic [1:0] ctrl_q;
   logic [1:0] ctrl_d;
   logic enable;
   logic soft_sd;
   assign enable = ctrl_q[tgp_pkg::CTRL_ENABLE_BIT];
   assign soft_sd = ctrl_q[tgp_pkg::CTRL_SOFT_SD_BIT];

   ////////////////////////////////////////////////////////////////////////
   // protection logic
   ////////////////////////////////////////////////////////////////////////
   logic all_low;
   logic sd_cause;
   logic sd_latch;
   logic oc_latch;
   // all six inputs low releases latched trips
   assign all_low = (hi_s == 3'h0) && (lo_s == 3'h0); // R3 R6
   // open pin reads as not connected, so no trip
   assign sd_cause = (sd_conn_s && !sd_n_s) || soft_sd; // R4 R17

   // shutdown latch with its delay
   tgp_trip_latch #(.DELAY_CYC(tgp_pkg::SD_DELAY_CYC)) u_sd_latch (
      .aclk(aclk),
      .aresetn(aresetn),
      .cause(sd_cause),
      .all_low(all_low),
      .tripped(sd_latch)
   ); // R2 R3

   // overcurrent latch with its delay
   tgp_trip_latch #(.DELAY_CYC(tgp_pkg::OC_DELAY_CYC)) u_oc_latch (
      .aclk(aclk),
      .aresetn(aresetn),
      .cause(oc_s),
      .all_low(all_low),
      .tripped(oc_latch)
   ); // R5 R6 R16

   // any trip that kills all six outputs
   logic kill_all;
   logic [2:0] shoot;
   logic fault_d;
   logic [2:0] gh_d;
   logic [2:0] gl_d;
   logic [2:0] gh_q;
   logic [2:0] gl_q;
   logic fault_q;

   // gate output decode
   always_comb begin
      // self clearing trips follow their inputs directly
      kill_all = sd_latch || oc_latch || luv_s || th_s || !enable; // R7 R8 R12 R13
      shoot = hi_s & lo_s; // R1
      gh_d = hi_s & ~shoot; // R1
      gl_d = lo_s & ~shoot; // R1
      if (buv_s) begin
         gh_d = 3'h0; // R10 R11
      end
      if (kill_all) begin
         gh_d = 3'h0;
         gl_d = 3'h0;
      end
      // shoot-through and bootstrap do not flag
      fault_d = sd_latch || oc_latch || luv_s || th_s; // R2 R5 R9 R12
   end

   // output registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gh_q <= 3'h0;
         gl_q <= 3'h0;
         fault_q <= 1'b0;
      end else begin
         gh_q <= gh_d;
         gl_q <= gl_d;
         fault_q <= fault_d;
      end
   end

   assign gate_high_u = gh_q[2];
   assign gate_high_v = gh_q[1];
   assign gate_high_w = gh_q[0];
   assign gate_low_u = gl_q[2];
   assign gate_low_v = gl_q[1];
   assign gate_low_w = gl_q[0];
   // open drain: pulls low while fault active
   assign fault_flag_o = 1'b0; // R15
   assign fault_flag_oe = fault_q; // R15

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel
   ////////////////////////////////////////////////////////////////////////
   logic aw_q;
   logic aw_d;
   logic w_q;
   logic w_d;
   logic [7:0] awaddr_q;
   logic [7:0] awaddr_d;
   logic [31:0] wdata_q;
   logic [31:0] wdata_d;
   logic [3:0] wstrb_q;
   logic [3:0] wstrb_d;
   logic bvalid_d;
   logic bvalid_q;
   logic [1:0] bresp_d;
   logic [1:0] bresp_q;

   // accept address and data in either order
   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready = !w_q && !bvalid_q;

   // write next state
   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      ctrl_d = ctrl_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      // both held: perform write and respond
      if (aw_q && w_q) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = tgp_pkg::RESP_OKAY;
         if (awaddr_q[7:2] == tgp_pkg::REG_CTRL[7:2]) begin
            if (wstrb_q[0]) begin
               ctrl_d = wdata_q[1:0];
            end
         end else if (!decoded(awaddr_q)) begin
            bresp_d = tgp_pkg::RESP_SLVERR;
         end
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // write registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         ctrl_q <= tgp_pkg::CTRL_RESET;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         ctrl_q <= ctrl_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   ////////////////////////////////////////////////////////////////////////
   // address map decode, shared by both channels
   function automatic logic decoded(input logic [7:0] a);
      decoded = (a[7:2] == tgp_pkg::REG_CTRL[7:2]) || (a[7:2] == tgp_pkg::REG_STATUS[7:2])
         || (a[7:2] == tgp_pkg::REG_INPUTS[7:2]) || (a[7:2] == tgp_pkg::REG_OUTPUTS[7:2]);
   endfunction

   logic rvalid_q;
   logic rvalid_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [1:0] rresp_q;
   logic [1:0] rresp_d;
   logic [6:0] status;
   assign status = {fault_q, |shoot, th_s, buv_s, luv_s, oc_latch, sd_latch};
   assign s_axi_arready = !rvalid_q;

   // read next state
   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d = decoded(s_axi_araddr) ? tgp_pkg::RESP_OKAY : tgp_pkg::RESP_SLVERR;
         rdata_d = 32'h0000_0000;
         if (s_axi_araddr[7:2] == tgp_pkg::REG_CTRL[7:2]) begin
            rdata_d = {30'h0, ctrl_q};
         end else if (s_axi_araddr[7:2] == tgp_pkg::REG_STATUS[7:2]) begin
            rdata_d = {25'h0, status};
         end else if (s_axi_araddr[7:2] == tgp_pkg::REG_INPUTS[7:2]) begin
            rdata_d = {24'h0, sd_n_s, sd_conn_s, hi_s, lo_s};
         end else if (s_axi_araddr[7:2] == tgp_pkg::REG_OUTPUTS[7:2]) begin
            rdata_d = {26'h0, gh_q, gl_q};
         end
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   // read registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'h0;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

/* File: rtl/tgp_pkg.sv */
// constants, types and register map of the gate protection block
// What this block does; R14 is left to the controller
// R1: both inputs high turns phase off, no flag
// R2: shutdown low forces all off after delay
// R3: shutdown latch holds until all inputs low
// R4: floating shutdown pin never trips shutdown
// R5: overcurrent turns outputs off after delay, flags
// R6: overcurrent latch released by all inputs low
// R7: logic undervoltage turns all outputs off
// R8: logic undervoltage clears itself, no release sequence
// R9: logic undervoltage asserts fault flag
// R10: bootstrap undervoltage blocks high side only, no flag
// R11: bootstrap recovery restores high side directly
// R12: thermal trip turns all off and flags
// R13: thermal trip clears itself with hysteresis
// R14: controller drives inputs after supply is stable
// R15: fault flag is open drain, on when abnormal
// R16: overcurrent delay typically 2 us, 3 us max
// R17: shutdown input active low, no hysteresis
// R18: trips enter synchronised, delays counted in cycles
package tgp_pkg;
   // clock period in picoseconds
   localparam int CLK_PERIOD_PS = 4000;
   // shutdown delay in nanoseconds
   localparam int SD_DELAY_NS = 2000;
   // overcurrent delay typical and max in nanoseconds
   localparam int OC_DELAY_NS = 2000;
   localparam int OC_DELAY_MAX_NS = 3000;
   // delay counts in cycles, at least one
   localparam int SD_DELAY_CYC = (SD_DELAY_NS * 1000) / CLK_PERIOD_PS;
   localparam int OC_DELAY_CYC = (OC_DELAY_NS * 1000) / CLK_PERIOD_PS;
   // delay counter width
   localparam int DLY_W = 10;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_INPUTS = 8'h08;
   localparam logic [7:0] REG_OUTPUTS = 8'h0C;
   // control field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_SOFT_SD_BIT = 1;
   // control reset value
   localparam logic [1:0] CTRL_RESET = 2'h1;
   // status field positions
   localparam int ST_SD_LATCH = 0;
   localparam int ST_OC_LATCH = 1;
   localparam int ST_LOGIC_UV = 2;
   localparam int ST_BOOT_UV = 3;
   localparam int ST_THERMAL = 4;
   localparam int ST_SHOOT = 5;
   localparam int ST_FAULT = 6;
   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // latch state of a latched trip
   typedef enum logic [1:0] {TGP_IDLE, TGP_WAIT, TGP_TRIP} tgp_trip_t;
endpackage

/* File: rtl/tgp_trip_latch.sv */
// delayed trip latch released by all phase inputs low
`timescale 1ns/1ps
`default_nettype none
module tgp_trip_latch #(
   parameter int DELAY_CYC = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cause,
   input wire logic all_low,
   output logic tripped
);
   // state and delay counter
   tgp_pkg::tgp_trip_t st_q;
   tgp_pkg::tgp_trip_t st_d;
   logic [tgp_pkg::DLY_W-1:0] cnt_q;
   logic [tgp_pkg::DLY_W-1:0] cnt_d;
   localparam logic [tgp_pkg::DLY_W-1:0] LAST = tgp_pkg::DLY_W'(DELAY_CYC - 1);

   // next state: wait the delay, then hold until all inputs low
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         tgp_pkg::TGP_IDLE: begin
            cnt_d = '0;
            if (cause) begin
               st_d = tgp_pkg::TGP_WAIT;
            end
         end
         tgp_pkg::TGP_WAIT: begin
            // delay runs on once the cause has been seen
            if (cnt_q >= LAST) begin
               st_d = tgp_pkg::TGP_TRIP;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         tgp_pkg::TGP_TRIP: begin
            // release only by all-low with cause gone
            if (all_low && !cause) begin
               st_d = tgp_pkg::TGP_IDLE;
            end
         end
         // unused code falls back to idle
         default: begin
            st_d = tgp_pkg::TGP_IDLE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= tgp_pkg::TGP_IDLE;
         cnt_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // tripped is the latched state
   assign tripped = (st_q == tgp_pkg::TGP_TRIP);
endmodule
`default_nettype wire

/* File: testbench/tgp_gate_protect_sva.sv */
// port-level assertions of the gate protection block
`timescale 1ns/1ps
`default_nettype none
module tgp_gate_protect_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_shutdown_n,
   input wire logic ext_shutdown_conn,
   input wire logic current_sense_trip,
   input wire logic logic_supply_uv,
   input wire logic bootstrap_uv,
   input wire logic thermal_trip,
   input wire logic gate_high_u,
   input wire logic gate_high_v,
   input wire logic gate_high_w,
   input wire logic gate_low_u,
   input wire logic gate_low_v,
   input wire logic gate_low_w,
   input wire logic fault_flag_o,
   input wire logic fault_flag_oe
);
   // all six switches off
   wire all_off = !(gate_high_u | gate_high_v | gate_high_w
      | gate_low_u | gate_low_v | gate_low_w);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   chk_no_shoot: assert property (!(gate_high_u && gate_low_u)
      && !(gate_high_v && gate_low_v) && !(gate_high_w && gate_low_w))
      else $error("phase with both switches on");
   chk_sd_delay: assert property ((!ext_shutdown_n && ext_shutdown_conn)[*3]
      |-> ##[0:505] (all_off && fault_flag_oe)) else $error("shutdown not taken in time");
   chk_oc_delay: assert property (current_sense_trip[*3]
      |-> ##[0:750] (all_off && fault_flag_oe)) else $error("overcurrent not taken in time");
   chk_uv_off: assert property (logic_supply_uv[*3] |=> all_off && fault_flag_oe)
      else $error("undervoltage left outputs on");
   chk_heat_off: assert property (thermal_trip[*3] |=> all_off && fault_flag_oe)
      else $error("thermal trip left outputs on");
   chk_boot_high: assert property (bootstrap_uv[*3]
      |=> !(gate_high_u || gate_high_v || gate_high_w))
      else $error("high side on during bootstrap undervoltage");
   chk_flag_od: assert property (fault_flag_o == 1'b0)
      else $error("fault flag drives high");
   chk_trip_quiet: assert property ($rose(gate_low_u)
      |-> !$past(logic_supply_uv, 3) && !$past(thermal_trip, 3)) else $error("switch on during trip");
endmodule
bind tgp_gate_protect tgp_gate_protect_sva chk (.*);
`default_nettype wire

/* File: testbench/tgp_ctrl_model.sv */
// controller model driving the six phase inputs
`timescale 1ns/1ps
`default_nettype none
module tgp_ctrl_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] pat,
   output logic [5:0] phase_q
);
   logic [5:0] phase_d;
   // inputs held low until the supply and reset have settled
   always_comb begin
      phase_d = aresetn ? pat : 6'h00;
   end
   // phase pattern registered as the controller would
   always_ff @(posedge aclk) begin
      phase_q <= phase_d;
   end
endmodule
`default_nettype wire

/* File: testbench/tgp_gate_protect_test.sv */
// self-checking bench of the gate protection block
`timescale 1ns/1ps
`default_nettype none
module tgp_gate_protect_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [5:0] pat = 6'h00;
   wire high_u_in, high_v_in, high_w_in, low_u_in, low_v_in, low_w_in;
   logic ext_shutdown_n = 1'b1, ext_shutdown_conn = 1'b1, current_sense_trip = 1'b0;
   logic logic_supply_uv = 1'b0, bootstrap_uv = 1'b0, thermal_trip = 1'b0;
   logic gate_high_u, gate_high_v, gate_high_w, gate_low_u, gate_low_v, gate_low_w;
   logic fault_flag_o, fault_flag_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d, s_axi_wdata = 32'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire [5:0] g = {gate_high_u, gate_high_v, gate_high_w, gate_low_u, gate_low_v, gate_low_w};
   int n_errors = 0, checks_done = 0, cycles = 0, i, k;
   // legal drive patterns and shoot-through patterns
   logic [5:0] norm [6] = '{6'h22, 6'h21, 6'h11, 6'h14, 6'h0C, 6'h0A};
   logic [5:0] shoot [3] = '{6'h24, 6'h12, 6'h09};
   always #2 aclk = ~aclk;
   tgp_ctrl_model ctl (.aclk(aclk), .aresetn(aresetn), .pat(pat),
      .phase_q({high_u_in, high_v_in, high_w_in, low_u_in, low_v_in, low_w_in}));
   tgp_gate_protect uut (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // hang guard
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // waits n edges, then samples gates and flag once settled
   task automatic see(input int n, input logic [5:0] eg, input logic eo);
      repeat (n) @(posedge aclk);
      #1;
      chk("gates", {26'h0, g}, {26'h0, eg});
      chk("flag", {31'h0, fault_flag_oe}, {31'h0, eo});
      @(posedge aclk);
   endtask
   // axi4-lite write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // axi4-lite read into d and r
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(tgp_pkg::REG_CTRL);
      chk("ctrl_reset", d, 32'h1);
      rd(8'h10);
      chk("bad_resp", {30'h0, r}, {30'h0, tgp_pkg::RESP_SLVERR});
      chk("bad_data", d, 32'h0);
      // normal drive follows the inputs
      for (i = 0; i < 6; i++) begin
         pat <= norm[i];
         see(6, norm[i], 1'b0);
      end
      rd(tgp_pkg::REG_OUTPUTS);
      chk("outputs", d, 32'h0A);
      rd(tgp_pkg::REG_INPUTS);
      chk("inputs", d, 32'hCA);
      for (i = 0; i < 3; i++) begin
         pat <= shoot[i];
         see(6, 6'h00, 1'b0);
      end
      // shoot-through shows in status but raises no fault
      rd(tgp_pkg::REG_STATUS);
      chk("shoot_status", d, 32'h20);
      pat <= 6'h22;
      bootstrap_uv <= 1'b1;
      see(6, 6'h02, 1'b0);
      bootstrap_uv <= 1'b0;
      see(6, 6'h22, 1'b0);
      // self-clearing trips: undervoltage then thermal
      for (k = 0; k < 2; k++) begin
         logic_supply_uv <= (k == 0);
         thermal_trip <= (k == 1);
         see(6, 6'h00, 1'b1);
         rd(tgp_pkg::REG_STATUS);
         chk("status", d, (k == 1) ? 32'h50 : 32'h44);
         logic_supply_uv <= 1'b0;
         thermal_trip <= 1'b0;
         see(6, 6'h22, 1'b0);
      end
      // latched trips: external shutdown then overcurrent, short pulse
      for (k = 0; k < 2; k++) begin
         ext_shutdown_n <= (k != 0);
         current_sense_trip <= (k == 1);
         repeat (3) @(posedge aclk);
         ext_shutdown_n <= 1'b1;
         current_sense_trip <= 1'b0;
         see(440, 6'h22, 1'b0);
         see(80, 6'h00, 1'b1);
         pat <= 6'h0C;
         see(6, 6'h00, 1'b1);
         pat <= 6'h00;
         see(6, 6'h00, 1'b0);
         pat <= 6'h22;
         see(6, 6'h22, 1'b0);
      end
      // open shutdown pin is ignored
      ext_shutdown_conn <= 1'b0;
      ext_shutdown_n <= 1'b0;
      see(20, 6'h22, 1'b0);
      ext_shutdown_n <= 1'b1;
      ext_shutdown_conn <= 1'b1;
      wr(tgp_pkg::REG_CTRL, 32'h0);
      see(6, 6'h00, 1'b0);
      wr(tgp_pkg::REG_CTRL, 32'h1);
      chk("wr_resp", {30'h0, r}, {30'h0, tgp_pkg::RESP_OKAY});
      see(6, 6'h22, 1'b0);
      // soft shutdown bit acts like the shutdown pin and latches
      wr(tgp_pkg::REG_CTRL, 32'h3);
      see(440, 6'h22, 1'b0);
      see(80, 6'h00, 1'b1);
      rd(tgp_pkg::REG_STATUS);
      chk("soft_status", d, 32'h41);
      wr(tgp_pkg::REG_CTRL, 32'h1);
      see(6, 6'h00, 1'b1);
      pat <= 6'h00;
      see(6, 6'h00, 1'b0);
      pat <= 6'h22;
      see(6, 6'h22, 1'b0);
      // write to an unmapped offset is refused
      wr(8'h10, 32'h0);
      chk("wr_bad_resp", {30'h0, r}, {30'h0, tgp_pkg::RESP_SLVERR});
      tally_and_finish();
   end
endmodule
`default_nettype wire
